// file: hdl/gsfb_consts.vh
// constants for the gauge status flag bank: command codes, bit positions,
// thresholds and reset values; included by the flag bank module only
`ifndef GSFB_CONSTS_VH
`define GSFB_CONSTS_VH

// serial command codes
`define GSFB_CMD_FLAGS 8'h2F
`define GSFB_CMD_MAX_ERR 8'h0C
`define GSFB_CMD_RESET 8'h44
// soft reset key (decimal 8009) and forbidden max error value
`define GSFB_RESET_KEY 16'h1F49
`define GSFB_MAX_ERR_BAD 16'h0002
`define GSFB_MAX_ERR_RST 16'h0000
`define GSFB_UNMAPPED_RD 16'hFFFF

// config_and_fault_flags bit positions
`define GSFB_B2_VIEW 7
`define GSFB_B2_CELL 5
`define GSFB_B2_FULL 4
`define GSFB_B2_OV 2
`define GSFB_B2_COLD 1
`define GSFB_B2_OC 0
// discharge_qualify_flags bit positions
`define GSFB_B1_VQ 5
`define GSFB_B1_LOCK 4
`define GSFB_B1_LEARN 3
`define GSFB_B1_HOLD 2
`define GSFB_B1_FIRST_LOW_VOLTAGE_FLAG 1
`define GSFB_B1_FINAL_LOW_VOLTAGE_FLAG 0

// pack voltage window in percent of charging voltage
`define GSFB_OV_SET_PCT 32'd105
`define GSFB_OV_CLR_PCT 32'd95
`define GSFB_PCT_BASE 32'd100
// temperatures in tenths of a degree C
`define GSFB_COLD_SET_DC 16'sh0000
`define GSFB_COLD_CLR_DC 16'sh0032
// overcurrent, in mA
`define GSFB_OC_LOW_CHG_MA 17'h00400
`define GSFB_OC_ADD_MA 17'h00100
`define GSFB_OC_CLR_MA 16'h0100
// heavy load hold at 6.15 A, in mA
`define GSFB_HOLD_MA 16'h1806
// self-discharge limit, in mAh
`define GSFB_SELF_DIS_MAH 16'h0100

// link state machine
`define GSFB_ST_IDLE 3'h0
`define GSFB_ST_RX 3'h1
`define GSFB_ST_ACK 3'h2
`define GSFB_ST_TX 3'h3
`define GSFB_ST_RACK 3'h4

`endif

// file: hdl/gsfb_flag_bank.v
// gauge status flag bank: two 8-bit flag registers, max error word and
// soft reset, reached over the two-wire serial port (scc clock, scd data).
// assumes measurement logic on clk supplies the quantities below, and that
// scc/scd arrive asynchronously from the host; scc is far slower than clk.
// Summary of operation
// - flags read as one word at 0x2f
// - bit 7 high selects relative capacity view
// - reserved flag bits carry no function, read zero
// - bit 5 selects lithium-ion over nickel compensation
// - bit 4 forces full charge on termination
// - overvoltage sets at 105%, clears at 95%
// - cold fault sets below 0C, clears above 5C
// - overcurrent over 125%, or +256mA when low
// - overcurrent clears below 256mA average current
// - charge qualified on sense and 10mAh accumulated
// - write lock rejects every register write
// - learning discharge flag set at full, cleared on faults
// - heavy load hold above 6.15A discharge
// - first low voltage flag with hold and qualify
// - final low voltage flag with hold and qualify
// - accepted reset reloads defaults from config memory
`timescale 1ns/1ns
`include "gsfb_consts.vh"

module gsfb_flag_bank #(
    parameter [6:0] DEV_ADDR = 7'h0B // slave address of the serial port
) (
    input wire clk, // 10 MHz system clock
    input wire sys_rst, // synchronous reset, active high
    input wire scc_in, // serial clock from host
    input wire scd_in, // serial data pin level
    output wire scd_out, // serial data drive value, always low
    output reg scd_oe, // serial data pulled low while high
    input wire [15:0] pack_mv, // pack voltage, mV
    input wire [15:0] charge_mv, // programmed charging voltage, mV
    input wire signed [15:0] temp_dc, // temperature, 0.1 degC
    input wire [15:0] avg_ma, // average charge current, mA
    input wire [15:0] charge_ma, // programmed charging current, mA
    input wire [15:0] dis_ma, // discharge current, mA
    input wire sense_charge, // sense input shows charge condition
    input wire acc_10mah, // 10 mAh of charge accumulated
    input wire discharging, // pack is discharging
    input wire dis_start, // pulse: a discharge begins
    input wire rm_full, // remaining charge equals full capacity
    input wire partial_charge, // pulse: partial charge detected
    input wire [15:0] self_dis_mah, // self-discharge in this discharge
    input wire [15:0] first_low_voltage_flag_mv, // first end-of-discharge threshold
    input wire [15:0] final_low_voltage_flag_mv, // final end-of-discharge threshold
    input wire terminate, // pulse: valid charge termination
    input wire cfg_valid, // pulse: config memory word ready
    input wire [3:0] cfg_bits, // view, cell, full, lock defaults
    output reg cfg_reload_req, // pulse: fetch defaults again
    output reg rm_force_full, // pulse: set remaining to full pct
    output wire capacity_view_select, // 1 relative, 0 absolute
    output wire cell_type_select, // 1 lithium-ion, 0 nickel
    output reg [15:0] max_error_r // max error estimate register
);

    reg [7:0] config_and_fault_flags_r; // config_and_fault_flags
    reg [7:0] discharge_qualify_flags_r; // discharge_qualify_flags
    reg [7:0] config_and_fault_flags_nxt;
    reg [7:0] discharge_qualify_flags_nxt;
    reg err_armed_r; // max error written with a legal value
    reg first_low_voltage_flag_d_r;

    // two flops on each pin before any logic looks at it
    reg scc_m_r, scc_s_r, scc_d_r, scd_m_r, scd_s_r, scd_d_r;
    wire scc_rise = scc_s_r & ~scc_d_r;
    wire scc_fall = ~scc_s_r & scc_d_r;
    wire bus_start = scc_s_r & scc_d_r & scd_d_r & ~scd_s_r;
    wire bus_stop = scc_s_r & scc_d_r & ~scd_d_r & scd_s_r;

    always @(posedge clk) begin
        if (sys_rst) begin
            scc_m_r <= 1'b1;
            scc_s_r <= 1'b1;
            scc_d_r <= 1'b1;
            scd_m_r <= 1'b1;
            scd_s_r <= 1'b1;
            scd_d_r <= 1'b1;
        end else begin
            scc_m_r <= scc_in;
            scc_s_r <= scc_m_r;
            scc_d_r <= scc_s_r;
            scd_m_r <= scd_in;
            scd_s_r <= scd_m_r;
            scd_d_r <= scd_s_r;
        end
    end

    assign scd_out = 1'b0;
    assign capacity_view_select = config_and_fault_flags_r[`GSFB_B2_VIEW];
    assign cell_type_select = config_and_fault_flags_r[`GSFB_B2_CELL];

    // threshold arithmetic, widened so products never wrap
    wire [31:0] pack_pct = {16'h0000, pack_mv} * `GSFB_PCT_BASE;
    wire [31:0] ov_set_lvl = {16'h0000, charge_mv} * `GSFB_OV_SET_PCT;
    wire [31:0] ov_clr_lvl = {16'h0000, charge_mv} * `GSFB_OV_CLR_PCT;
    wire [16:0] chg17 = {1'b0, charge_ma};
    wire [16:0] oc_lvl = (chg17 < `GSFB_OC_LOW_CHG_MA) ? (chg17 + `GSFB_OC_ADD_MA)
                                                      : (chg17 + {2'b00, chg17[16:2]});
    wire first_low_voltage_flag_now = discharge_qualify_flags_nxt[`GSFB_B1_FIRST_LOW_VOLTAGE_FLAG];

    // link state
    reg [2:0] st_r;
    reg [2:0] bit_r;
    reg [7:0] sh_r;
    reg [1:0] byte_r; // 0 addr, 1 cmd, 2 low, 3 high
    reg rd_r; // current transfer is a read
    reg hold_r; // byte just completed, ack slot pending
    reg ack_r; // pending slot is to be acked
    reg [7:0] cmd_r;
    reg [7:0] wlo_r;
    reg [15:0] rdw_r; // word latched for a read
    reg hi_sent_r;
    reg mack_r;
    reg wr_go_r; // pulse: write word complete and accepted
    reg [15:0] wr_word_r;

    wire [15:0] rd_word = (cmd_r == `GSFB_CMD_FLAGS) ? {config_and_fault_flags_r, discharge_qualify_flags_r} :
                          (cmd_r == `GSFB_CMD_MAX_ERR) ? max_error_r : `GSFB_UNMAPPED_RD;
    wire [7:0] rx_byte = {sh_r[6:0], scd_s_r};

    // serial byte engine: bits in on rising scc, drive on falling scc.
    // stop or a new start always abandons a transfer, so a stuck host
    // cannot wedge the port beyond the next start
    always @(posedge clk) begin
        if (sys_rst) begin
            st_r <= `GSFB_ST_IDLE;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            byte_r <= 2'h0;
            rd_r <= 1'b0;
            hold_r <= 1'b0;
            ack_r <= 1'b0;
            cmd_r <= 8'h00;
            wlo_r <= 8'h00;
            rdw_r <= 16'h0000;
            hi_sent_r <= 1'b0;
            mack_r <= 1'b1;
            wr_go_r <= 1'b0;
            wr_word_r <= 16'h0000;
            scd_oe <= 1'b0;
        end else begin
            wr_go_r <= 1'b0;
            if (bus_start) begin
                st_r <= `GSFB_ST_RX;
                bit_r <= 3'h0;
                byte_r <= 2'h0;
                hold_r <= 1'b0;
                scd_oe <= 1'b0;
            end else if (bus_stop) begin
                st_r <= `GSFB_ST_IDLE;
                scd_oe <= 1'b0;
            end else begin
                case (st_r)
                    `GSFB_ST_RX: begin
                        if (scc_rise & ~hold_r) begin
                            sh_r <= rx_byte;
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == 3'h7) begin
                                hold_r <= 1'b1;
                                case (byte_r)
                                    2'h0: begin
                                        ack_r <= (rx_byte[7:1] == DEV_ADDR);
                                        rd_r <= rx_byte[0];
                                    end
                                    2'h1: begin
                                        ack_r <= 1'b1;
                                        cmd_r <= rx_byte;
                                    end
                                    2'h2: begin
                                        ack_r <= ~discharge_qualify_flags_r[`GSFB_B1_LOCK];
                                        wlo_r <= rx_byte;
                                    end
                                    default: begin
                                        ack_r <= ~discharge_qualify_flags_r[`GSFB_B1_LOCK];
                                        wr_word_r <= {rx_byte, wlo_r};
                                        wr_go_r <= ~discharge_qualify_flags_r[`GSFB_B1_LOCK];
                                    end
                                endcase
                            end
                        end else if (scc_fall & hold_r) begin
                            hold_r <= 1'b0;
                            if (ack_r) begin
                                scd_oe <= 1'b1;
                                st_r <= `GSFB_ST_ACK;
                            end else begin
                                st_r <= `GSFB_ST_IDLE;
                            end
                        end
                    end
                    `GSFB_ST_ACK: begin
                        if (scc_fall) begin
                            bit_r <= 3'h0;
                            if (rd_r & (byte_r == 2'h0)) begin
                                rdw_r <= rd_word;
                                sh_r <= rd_word[7:0];
                                scd_oe <= ~rd_word[7];
                                hi_sent_r <= 1'b0;
                                st_r <= `GSFB_ST_TX;
                            end else begin
                                scd_oe <= 1'b0;
                                byte_r <= byte_r + 2'h1;
                                st_r <= `GSFB_ST_RX;
                            end
                        end
                    end
                    `GSFB_ST_TX: begin
                        if (scc_rise) begin
                            bit_r <= bit_r + 3'h1;
                        end else if (scc_fall) begin
                            if (bit_r == 3'h0) begin
                                scd_oe <= 1'b0;
                                st_r <= `GSFB_ST_RACK;
                            end else begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                scd_oe <= ~sh_r[6];
                            end
                        end
                    end
                    `GSFB_ST_RACK: begin
                        if (scc_rise) begin
                            mack_r <= scd_s_r;
                        end else if (scc_fall) begin
                            if (~mack_r & ~hi_sent_r) begin
                                hi_sent_r <= 1'b1;
                                sh_r <= rdw_r[15:8];
                                scd_oe <= ~rdw_r[15];
                                bit_r <= 3'h0;
                                st_r <= `GSFB_ST_TX;
                            end else begin
                                st_r <= `GSFB_ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        scd_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // each flag keeps its value between set and clear levels
    always @* begin
        config_and_fault_flags_nxt = config_and_fault_flags_r;
        discharge_qualify_flags_nxt = discharge_qualify_flags_r;
        if (pack_pct >= ov_set_lvl)
            config_and_fault_flags_nxt[`GSFB_B2_OV] = 1'b1;
        else if (pack_pct <= ov_clr_lvl)
            config_and_fault_flags_nxt[`GSFB_B2_OV] = 1'b0;
        if (temp_dc < `GSFB_COLD_SET_DC)
            config_and_fault_flags_nxt[`GSFB_B2_COLD] = 1'b1;
        else if (temp_dc > `GSFB_COLD_CLR_DC)
            config_and_fault_flags_nxt[`GSFB_B2_COLD] = 1'b0;
        if ({1'b0, avg_ma} > oc_lvl)
            config_and_fault_flags_nxt[`GSFB_B2_OC] = 1'b1;
        else if (avg_ma < `GSFB_OC_CLR_MA)
            config_and_fault_flags_nxt[`GSFB_B2_OC] = 1'b0;
        if (discharging | ~sense_charge)
            discharge_qualify_flags_nxt[`GSFB_B1_VQ] = 1'b0;
        else if (acc_10mah)
            discharge_qualify_flags_nxt[`GSFB_B1_VQ] = 1'b1;
        if (dis_ma > `GSFB_HOLD_MA)
            discharge_qualify_flags_nxt[`GSFB_B1_HOLD] = 1'b1;
        else if (dis_ma < `GSFB_HOLD_MA)
            discharge_qualify_flags_nxt[`GSFB_B1_HOLD] = 1'b0;
        if ((pack_mv < first_low_voltage_flag_mv) & ~discharge_qualify_flags_r[`GSFB_B1_HOLD])
            discharge_qualify_flags_nxt[`GSFB_B1_FIRST_LOW_VOLTAGE_FLAG] = 1'b1;
        else if (discharge_qualify_flags_r[`GSFB_B1_VQ] & (pack_mv > first_low_voltage_flag_mv))
            discharge_qualify_flags_nxt[`GSFB_B1_FIRST_LOW_VOLTAGE_FLAG] = 1'b0;
        if ((pack_mv < final_low_voltage_flag_mv) & ~discharge_qualify_flags_r[`GSFB_B1_HOLD])
            discharge_qualify_flags_nxt[`GSFB_B1_FINAL_LOW_VOLTAGE_FLAG] = 1'b1;
        else if (discharge_qualify_flags_r[`GSFB_B1_VQ] & (pack_mv > final_low_voltage_flag_mv))
            discharge_qualify_flags_nxt[`GSFB_B1_FINAL_LOW_VOLTAGE_FLAG] = 1'b0;
        config_and_fault_flags_nxt[6] = 1'b0;
        config_and_fault_flags_nxt[3] = 1'b0;
        discharge_qualify_flags_nxt[7:6] = 2'b00;
    end

    // flag registers, max error and the soft reset sequence
    always @(posedge clk) begin
        if (sys_rst) begin
            config_and_fault_flags_r <= 8'h00;
            discharge_qualify_flags_r <= 8'h00;
            max_error_r <= `GSFB_MAX_ERR_RST;
            err_armed_r <= 1'b0;
            first_low_voltage_flag_d_r <= 1'b0;
            cfg_reload_req <= 1'b1;
            rm_force_full <= 1'b0;
        end else begin
            config_and_fault_flags_r <= config_and_fault_flags_nxt;
            discharge_qualify_flags_r <= discharge_qualify_flags_nxt;
            first_low_voltage_flag_d_r <= first_low_voltage_flag_now;
            cfg_reload_req <= 1'b0;
            rm_force_full <= terminate & config_and_fault_flags_r[`GSFB_B2_FULL];
            // learning discharge qualification, clears take priority
            if (partial_charge | (self_dis_mah > `GSFB_SELF_DIS_MAH) |
                (first_low_voltage_flag_now & ~first_low_voltage_flag_d_r & (temp_dc < `GSFB_COLD_SET_DC)))
                discharge_qualify_flags_r[`GSFB_B1_LEARN] <= 1'b0;
            else if (dis_start & rm_full)
                discharge_qualify_flags_r[`GSFB_B1_LEARN] <= 1'b1;
            if (cfg_valid) begin
                config_and_fault_flags_r[`GSFB_B2_VIEW] <= cfg_bits[3];
                config_and_fault_flags_r[`GSFB_B2_CELL] <= cfg_bits[2];
                config_and_fault_flags_r[`GSFB_B2_FULL] <= cfg_bits[1];
                discharge_qualify_flags_r[`GSFB_B1_LOCK] <= cfg_bits[0];
            end
            // writes only arrive here when unlocked
            if (wr_go_r) begin
                if (cmd_r == `GSFB_CMD_MAX_ERR) begin
                    max_error_r <= wr_word_r;
                    err_armed_r <= (wr_word_r != `GSFB_MAX_ERR_BAD);
                end else if (cmd_r == `GSFB_CMD_RESET) begin
                    err_armed_r <= 1'b0;
                    // reset key accepted after armed max error
                    if (err_armed_r & (wr_word_r == `GSFB_RESET_KEY)) begin
                        config_and_fault_flags_r <= 8'h00;
                        discharge_qualify_flags_r <= 8'h00;
                        max_error_r <= `GSFB_MAX_ERR_RST;
                        cfg_reload_req <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

// file: bench/gsfb_host_model.sv
// serial host model: start, stop, byte and word transfers on scc and scd
// assumes the bench resolves the data line from host drive and scd_oe
`timescale 1ns/1ns
module gsfb_host_model #(
    parameter logic [6:0] ADDR = 7'h0B // slave address of the flag bank
) (
    output logic scc, // serial clock, idle high, still between frames
    output logic sdh, // host data drive, 1 lets the pull-up win
    input wire logic line // resolved data line
);
    logic v;
    // idle bus: both lines released
    initial begin
        scc = 1'b1;
        sdh = 1'b1;
    end
    // one 800 ns slot; data moves only while scc is low
    task automatic bit_x(input logic b, output logic s);
        sdh = b;
        #200 scc = 1'b1;
        #200 s = line;
        #200 scc = 1'b0;
        #200;
    endtask
    // start or repeated start; the lead-in gives the part time to drop its ack
    task automatic start;
        #200 sdh = 1'b1;
        #200 scc = 1'b1;
        #200 sdh = 1'b0;
        #200 scc = 1'b0;
        #200;
    endtask
    task automatic stop;
        sdh = 1'b0;
        #200 scc = 1'b1;
        #200 sdh = 1'b1;
        #400;
    endtask
    // byte out msb first, then the ack slot; ack is the line pulled low
    task automatic tx(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_x(d[i], v);
        bit_x(1'b1, v);
        ack = ~v;
    endtask
    // byte in; the last byte is answered with a nack to end the read
    task automatic rx(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, v);
    endtask
    task automatic wr_word(input logic [7:0] c, input logic [15:0] w, output logic ok);
        logic a, b, e, f;
        start;
        tx({ADDR, 1'b0}, a);
        tx(c, b);
        tx(w[7:0], e);
        tx(w[15:8], f);
        stop;
        ok = a & b & e & f;
    endtask
    task automatic rd_word(input logic [7:0] c, output logic [15:0] w);
        logic a;
        start;
        tx({ADDR, 1'b0}, a);
        tx(c, a);
        start;
        tx({ADDR, 1'b1}, a);
        rx(1'b0, w[7:0]);
        rx(1'b1, w[15:8]);
        stop;
    endtask
endmodule

// file: bench/gsfb_flag_bank_asserts.sv
// port assertions for the flag bank: acked register changes, reload and
// force-full pulses, config outputs
// assumes one clk domain with sys_rst synchronous, active high
`timescale 1ns/1ns
module gsfb_flag_bank_asserts (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset
    input wire logic scd_out, // data drive value
    input wire logic scd_oe, // data pull-down enable
    input wire logic terminate, // charge termination pulse
    input wire logic cfg_valid, // config word strobe
    input wire logic cfg_reload_req, // reload request pulse
    input wire logic rm_force_full, // force full pulse
    input wire logic capacity_view_select, // view output
    input wire logic cell_type_select, // cell output
    input wire logic [15:0] max_error_r // max error word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // an update lands before its ack slot, so the pull-down follows soon
    sequence s_ack_soon;
        ##[0:20] scd_oe;
    endsequence
    sequence s_one_pulse;
        cfg_reload_req ##1 !cfg_reload_req;
    endsequence
    a_maxerr_acked: assert property (!$stable(max_error_r) |-> s_ack_soon)
        else $error("max error changed without an ack");
    a_reload_single: assert property (cfg_reload_req |-> s_one_pulse)
        else $error("reload request longer than one cycle");
    a_reload_clears: assert property (cfg_reload_req |=> max_error_r == 16'h0000)
        else $error("max error not cleared by reload");
    a_view_cause: assert property (!$stable(capacity_view_select) |->
        ($past(cfg_valid) || cfg_reload_req || $past(cfg_reload_req)))
        else $error("view select moved without a config load");
    a_cell_cause: assert property (!$stable(cell_type_select) |->
        ($past(cfg_valid) || cfg_reload_req || $past(cfg_reload_req)))
        else $error("cell select moved without a config load");
    a_force_cause: assert property (rm_force_full |-> $past(terminate))
        else $error("force full without a termination");
    a_force_single: assert property (rm_force_full && !terminate |=> !rm_force_full)
        else $error("force full pulse too long");
    a_drive_low: assert property (scd_out == 1'b0)
        else $error("data drive value not low");
endmodule
bind gsfb_flag_bank gsfb_flag_bank_asserts chk_u (.clk, .sys_rst, .scd_out, .scd_oe,
    .terminate, .cfg_valid, .cfg_reload_req, .rm_force_full, .capacity_view_select,
    .cell_type_select, .max_error_r);

// file: bench/gsfb_flag_bank_tb.sv
// testbench for the flag bank: drives measurements and talks through the host model
// assumes the data line has a pull-up; flags are seen through serial reads, the view and cell bits also on their output ports
`timescale 1ns/1ns
module gsfb_flag_bank_tb;
    logic clk = 1'b0, sys_rst = 1'b1, scc_in, sdh, scd_in, scd_out, scd_oe;
    logic sense_charge = 1'b0, acc_10mah = 1'b0, discharging = 1'b0, dis_start = 1'b0;
    logic rm_full = 1'b0, partial_charge = 1'b0, terminate = 1'b0, cfg_valid = 1'b0;
    logic cfg_reload_req, rm_force_full, capacity_view_select, cell_type_select;
    logic [3:0] cfg_bits = 4'h0;
    logic [15:0] pack_mv = 16'h2710, charge_mv = 16'h2710, avg_ma = 16'h0000;
    logic [15:0] charge_ma = 16'h07D0, dis_ma = 16'h0000, self_dis_mah = 16'h0000;
    logic [15:0] first_low_voltage_flag_mv = 16'h2328, final_low_voltage_flag_mv = 16'h1F40, max_error_r;
    logic signed [15:0] temp_dc = 16'sh00C8;
    int fails = 0, total_checks = 0, reloads = 0;
    // clock, wired-and data line, reload pulse counter
    always #50 clk = ~clk;
    assign scd_in = sdh & ~scd_oe;
    // the request also stands while reset is held; only count it once reset is gone
    always @(posedge clk) if (!sys_rst && cfg_reload_req === 1'b1) reloads++;
    gsfb_flag_bank dut_u (.clk, .sys_rst, .scc_in, .scd_in, .scd_out, .scd_oe, .pack_mv,
        .charge_mv, .temp_dc, .avg_ma, .charge_ma, .dis_ma, .sense_charge, .acc_10mah,
        .discharging, .dis_start, .rm_full, .partial_charge, .self_dis_mah, .first_low_voltage_flag_mv,
        .final_low_voltage_flag_mv, .terminate, .cfg_valid, .cfg_bits, .cfg_reload_req, .rm_force_full,
        .capacity_view_select, .cell_type_select, .max_error_r);
    gsfb_host_model host_u (.scc(scc_in), .sdh, .line(scd_in));
    task automatic close_out;
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // inputs always move 1 ns after a rising edge
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // let flags settle, then read the flag word and compare the masked bits
    task automatic fl(input string nm, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] w;
        at(3);
        host_u.rd_word(8'h2F, w);
        chk(nm, w & m, e);
    endtask
    task automatic cfg(input logic [3:0] b);
        at(1);
        cfg_bits = b;
        cfg_valid = 1'b1;
        at(1);
        cfg_valid = 1'b0;
    endtask
    // termination pulse; the force pulse is looked for over a few cycles only
    task automatic term_chk(input logic e);
        logic got;
        got = 1'b0;
        at(1);
        terminate = 1'b1;
        at(1);
        terminate = 1'b0;
        repeat (3) begin
            if (rm_force_full === 1'b1) got = 1'b1;
            at(1);
        end
        chk("force_full", 16'(got), 16'(e));
    endtask
    task automatic sc_reset;
        logic [15:0] w;
        chk("reloads", 16'(reloads), 16'h0001);
        chk("max_err", max_error_r, 16'h0000);
        fl("flags_rst", 16'hFFFF, 16'h0000);
        host_u.rd_word(8'h55, w);
        chk("unmapped", w, 16'hFFFF);
    endtask
    task automatic sc_config;
        cfg(4'hE);
        chk("view", 16'(capacity_view_select), 16'h0001);
        chk("cell", 16'(cell_type_select), 16'h0001);
        fl("cfg_word", 16'hFFFF, 16'hB000);
        term_chk(1'b1);
        cfg(4'h0);
        chk("view_off", 16'(capacity_view_select), 16'h0000);
        term_chk(1'b0);
    endtask
    task automatic sc_volt_temp;
        at(1);
        pack_mv = 16'h2904;
        temp_dc = 16'shFFFF;
        fl("ovc_set", 16'h0600, 16'h0600);
        at(1);
        pack_mv = 16'h2710;
        temp_dc = 16'sh001E;
        fl("ovc_hold", 16'h0600, 16'h0600);
        at(1);
        pack_mv = 16'h24B8;
        temp_dc = 16'sh0033;
        fl("ovc_clr", 16'h0600, 16'h0000);
    endtask
    task automatic sc_current;
        at(1);
        avg_ma = 16'h09C4;
        fl("oc_edge", 16'h0100, 16'h0000);
        at(1);
        avg_ma = 16'h09C5;
        fl("oc_set", 16'h0100, 16'h0100);
        at(1);
        avg_ma = 16'h012C;
        fl("oc_hold", 16'h0100, 16'h0100);
        at(1);
        avg_ma = 16'h00FF;
        fl("oc_clr", 16'h0100, 16'h0000);
        at(1);
        charge_ma = 16'h0320;
        avg_ma = 16'h0421;
        fl("oc_low", 16'h0100, 16'h0100);
    endtask
    task automatic sc_low_volt;
        // hold must stand before the voltage drops, else both low flags set at once
        at(1);
        dis_ma = 16'h1807;
        at(2);
        pack_mv = 16'h1B58;
        fl("hold_only", 16'h0007, 16'h0004);
        at(1);
        dis_ma = 16'h1770;
        fl("edv_set", 16'h0007, 16'h0003);
        at(1);
        pack_mv = 16'h251C;
        fl("edv_keep", 16'h0023, 16'h0003);
        at(1);
        sense_charge = 1'b1;
        acc_10mah = 1'b1;
        fl("edv_clr", 16'h0023, 16'h0020);
        at(1);
        discharging = 1'b1;
        fl("vq_clr", 16'h0020, 16'h0000);
    endtask
    task automatic sc_learn;
        at(1);
        rm_full = 1'b1;
        dis_start = 1'b1;
        at(1);
        dis_start = 1'b0;
        fl("learn_set", 16'h0008, 16'h0008);
        at(1);
        self_dis_mah = 16'h0101;
        fl("learn_clr", 16'h0008, 16'h0000);
    endtask
    task automatic sc_lock;
        logic ok;
        cfg(4'h1);
        fl("lock_bit", 16'h0010, 16'h0010);
        host_u.wr_word(8'h0C, 16'h1234, ok);
        chk("lock_nack", 16'(ok), 16'h0000);
        chk("lock_keep", max_error_r, 16'h0000);
        cfg(4'h0);
        host_u.wr_word(8'h0C, 16'h1234, ok);
        chk("wr_ack", 16'(ok), 16'h0001);
        chk("wr_val", max_error_r, 16'h1234);
    endtask
    task automatic sc_soft_reset;
        logic ok;
        int r0;
        cfg(4'hE);
        host_u.wr_word(8'h0C, 16'h0002, ok);
        host_u.wr_word(8'h44, 16'h1F49, ok);
        chk("not_armed", max_error_r, 16'h0002);
        // host confirms the lock is clear, arms with a value other than 2, sends the key
        fl("unlocked", 16'h0010, 16'h0000);
        r0 = reloads;
        host_u.wr_word(8'h0C, 16'h0005, ok);
        host_u.wr_word(8'h44, 16'h1F49, ok);
        at(3);
        chk("reload", 16'(reloads - r0), 16'h0001);
        chk("rst_err", max_error_r, 16'h0000);
        fl("rst_cfg", 16'hB000, 16'h0000);
    endtask
    // main sequence: reset for 6 cycles, then every scenario in turn
    initial begin
        at(6);
        sys_rst = 1'b0;
        at(4);
        sc_reset;
        sc_config;
        sc_volt_temp;
        sc_current;
        sc_low_volt;
        sc_learn;
        sc_lock;
        sc_soft_reset;
        close_out;
    end
    // hang guard: running out counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        close_out;
    end
endmodule
